// ==== hdl/phbp_params.svh ====
// Summary of operation
// - Async read without pending write holds busy for the internal read time, 235/315 ns.
// - A read arriving during a pending write finishes that write first, 180/260 ns; the read after it still takes the full 235/315 ns.
// - Read right after a byte write to the same address adds 20 ns.
// - Delayed read-busy option stretches busy at the end of a read by 20 ns.
// - Writes are posted; busy only while an earlier write is still running, 200/280 ns.
// - Busy is driven only while chip select is active; internal writes still finish.
// - Read during internal write keeps busy through write and read until data valid.
// - Read data held while address and byte enable stand; bus released on strobe end.
// - Interrupt output is valid no later than the loaded indication is raised.
// - Synchronous port chosen by interface type 0x0a (16 bit) or 0x0b (8 bit).
// - Low address bit with byte-high enable: 00 word, 01 low, 10 high, 11 invalid.
// - 8-bit port moves one byte per access; 16-bit port takes byte and word accesses.
// - Little endian: even byte on data 7..0, odd byte on data 15..8.
// - Invalid access bumps the interface error counter and is not performed.
// - Sync port accepts chip select with transfer start or one clock later.
// - Sync port pulses transfer acknowledge one clock, with read data on reads.
`ifndef PHBP_PARAMS_SVH
`define PHBP_PARAMS_SVH

`define PHBP_CLK_PERIOD_NS      8
`define PHBP_T_READ8_NS         235
`define PHBP_T_READ16_NS        315
`define PHBP_T_PWR8_NS          180
`define PHBP_T_PWR16_NS         260
`define PHBP_T_WRITE8_NS        200
`define PHBP_T_WRITE16_NS       280
`define PHBP_T_COLL_NS          20
`define PHBP_T_RDDLY_NS         20
// Longest times round down to whole cycles
`define PHBP_CYC(ns)            ((ns) / `PHBP_CLK_PERIOD_NS)
`define PHBP_TYPE_ASYNC16       8'h08
`define PHBP_TYPE_ASYNC8        8'h09
`define PHBP_TYPE_SYNC16        8'h0a
`define PHBP_TYPE_SYNC8         8'h0b
`define PHBP_ERRCNT_RESET       8'h00

`endif

// ==== hdl/phbp_pkg.sv ====
package phbp_pkg;

    // Byte lane decode result
    typedef enum logic [1:0] {
        PHBP_ACC_WORD,
        PHBP_ACC_LOW,
        PHBP_ACC_HIGH,
        PHBP_ACC_BAD
    } phbp_acc_t;

    // One access toward the internal memory
    typedef struct packed {
        logic        write;
        logic [15:0] addr;
        logic [1:0]  lanes;
        logic [15:0] wdata;
    } phbp_req_t;

    // Host-side pins of the parallel port
    typedef struct packed {
        logic        cs_n;
        logic        rd_n;
        logic        wr_n;
        logic        byte_high_enable_n;
        logic [15:0] addr;
        logic [15:0] data;
    } phbp_pins_t;

endpackage : phbp_pkg

// ==== hdl/phbp_sync_port.sv ====
`timescale 1ns/10ps
`include "phbp_params.svh"
// Synchronous variant front end, running on the host interface clock.
// Hands one request over by toggle and takes the done toggle back.
module phbp_sync_port (
    input  wire logic               host_clk,
    input  wire logic               host_rst,
    input  wire logic               enable,
    input  wire logic               wide,
    input  wire logic               cs_n,
    input  wire logic               transfer_start_strobe_n,
    input  wire logic               read_not_write_select,
    input  wire logic               byte_high_enable_n,
    input  wire logic [15:0]        addr,
    input  wire logic [15:0]        wdata,
    output logic                    req_tgl,
    output phbp_pkg::phbp_req_t     req,
    input  wire logic               done_tgl,
    input  wire logic [15:0]        rdata,
    output logic                    transfer_ack_n,
    output logic [15:0]             dout,
    output logic                    dout_oe
);
    import phbp_pkg::*;

    typedef enum logic [1:0] {PHBP_S_IDLE, PHBP_S_CSWAIT, PHBP_S_BUSY} phbp_sstate_t;
    phbp_sstate_t st_r;
    logic         done_s1_r, done_s2_r, done_seen_r;
    logic         is_rd_r;

    // Request issue and completion tracking
    always_ff @(posedge host_clk) begin
        if (host_rst) begin
            st_r     <= PHBP_S_IDLE;
            req_tgl  <= 1'b0;
            req      <= '0;
            is_rd_r  <= 1'b0;
        end else begin
            case (st_r)
                PHBP_S_IDLE: begin
                    if (enable && !transfer_start_strobe_n) begin
                        req.write <= !read_not_write_select;
                        req.addr  <= addr;
                        req.wdata <= wdata;
                        req.lanes <= !wide ? (addr[0] ? 2'b10 : 2'b01) :
                                     {!byte_high_enable_n, !addr[0]};
                        is_rd_r   <= read_not_write_select;
                        if (!cs_n) begin
                            req_tgl <= !req_tgl;
                            st_r    <= PHBP_S_BUSY;
                        end else begin
                            st_r    <= PHBP_S_CSWAIT;
                        end
                    end
                end
                PHBP_S_CSWAIT: begin
                    // Chip select one clock late is still taken
                    if (!cs_n) begin
                        req_tgl <= !req_tgl;
                        st_r    <= PHBP_S_BUSY;
                    end else begin
                        st_r    <= PHBP_S_IDLE;
                    end
                end
                PHBP_S_BUSY: begin
                    if (done_s2_r != done_seen_r) begin
                        st_r <= PHBP_S_IDLE;
                    end
                end
                default: st_r <= PHBP_S_IDLE;
            endcase
        end
    end

    // Done toggle crosses in through two flops
    always_ff @(posedge host_clk) begin
        if (host_rst) begin
            done_s1_r   <= 1'b0;
            done_s2_r   <= 1'b0;
            done_seen_r <= 1'b0;
        end else begin
            done_s1_r   <= done_tgl;
            done_s2_r   <= done_s1_r;
            done_seen_r <= done_s2_r;
        end
    end

    // One-cycle acknowledge, read data beside it
    always_ff @(posedge host_clk) begin
        if (host_rst) begin
            transfer_ack_n <= 1'b1;
            dout           <= 16'h0000;
            dout_oe        <= 1'b0;
        end else begin
            transfer_ack_n <= !(st_r == PHBP_S_BUSY && done_s2_r != done_seen_r);
            dout_oe        <= st_r == PHBP_S_BUSY && done_s2_r != done_seen_r && is_rd_r;
            if (st_r == PHBP_S_BUSY && done_s2_r != done_seen_r) begin
                dout <= rdata;
            end
        end
    end

endmodule : phbp_sync_port

// ==== hdl/phbp_host_port.sv ====
`timescale 1ns/10ps
`include "phbp_params.svh"
// Parallel host port: async strobe/busy variant on ref_clk, sync variant on
// host_clk. Internal memory is reached by mem_req/mem_valid on ref_clk.
module phbp_host_port #(
    parameter int RD8_CYC  = `PHBP_CYC(`PHBP_T_READ8_NS),
    parameter int RD16_CYC = `PHBP_CYC(`PHBP_T_READ16_NS),
    parameter int WR8_CYC  = `PHBP_CYC(`PHBP_T_WRITE8_NS),
    parameter int WR16_CYC = `PHBP_CYC(`PHBP_T_WRITE16_NS),
    parameter int COLL_CYC = `PHBP_CYC(`PHBP_T_COLL_NS),
    parameter int RDDLY_CYC = `PHBP_CYC(`PHBP_T_RDDLY_NS)
) (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic               host_clk,
    input  wire logic               host_rst,
    input  wire logic [7:0]         interface_type,
    input  wire logic               read_busy_delay,
    input  wire logic               config_loaded,
    input  wire logic               irq_in,
    input  wire phbp_pkg::phbp_pins_t pins,
    input  wire logic               transfer_start_strobe_n,
    input  wire logic               read_not_write_select,
    output logic [15:0]             data_out,
    output logic                    data_oe,
    output logic                    busy_n,
    output logic                    busy_oe,
    output logic                    transfer_ack_n,
    output logic                    sync_data_oe,
    output logic [15:0]             sync_data_out,
    output logic                    irq_n,
    output logic                    loaded,
    output logic [7:0]              error_count,
    output phbp_pkg::phbp_req_t     mem_req,
    output logic                    mem_valid,
    input  wire logic [15:0]        mem_rdata
);
    import phbp_pkg::*;

    typedef enum logic [1:0] {PHBP_A_IDLE, PHBP_A_READ, PHBP_A_HOLD} phbp_astate_t;

    // Lane decode used by the async variant
    function automatic phbp_acc_t phbp_decode(input logic a0, input logic bhe_n);
        case ({a0, bhe_n})
            2'b00:   phbp_decode = PHBP_ACC_WORD;
            2'b01:   phbp_decode = PHBP_ACC_LOW;
            2'b10:   phbp_decode = PHBP_ACC_HIGH;
            default: phbp_decode = PHBP_ACC_BAD;
        endcase
    endfunction : phbp_decode

    logic         is_sync, is_async, wide;
    logic [2:0]   cs_s_r, rd_s_r, wr_s_r;
    phbp_astate_t ast_r;
    logic [5:0]   wcnt_r, rcnt_r;
    logic         wpend_r, rd_pend_r;
    logic [15:0]  last_waddr_r;
    logic         last_wbyte_r, last_wvalid_r;
    logic [15:0]  rd_addr_r;
    logic         rd_bhe_r;
    logic         cfg_sync_r, cfg_async_r, cfg_wide_r;
    logic         sreq_tgl, sdone_tgl_r;
    logic [3:0]   sreq_s_r;
    phbp_req_t    sreq;
    logic         cs_act, rd_act, wr_act, rd_fall, wr_rise;
    phbp_acc_t    acc;
    logic [15:0]  held_rdata_r;

    // Configuration decode, registered in the core domain
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_sync_r  <= 1'b0;
            cfg_async_r <= 1'b0;
            cfg_wide_r  <= 1'b0;
        end else begin
            cfg_sync_r  <= interface_type == `PHBP_TYPE_SYNC16 ||
                           interface_type == `PHBP_TYPE_SYNC8;
            cfg_async_r <= interface_type == `PHBP_TYPE_ASYNC16 ||
                           interface_type == `PHBP_TYPE_ASYNC8;
            cfg_wide_r  <= interface_type == `PHBP_TYPE_SYNC16 ||
                           interface_type == `PHBP_TYPE_ASYNC16;
        end
    end
    assign is_sync  = cfg_sync_r && config_loaded;
    assign is_async = cfg_async_r && config_loaded;
    assign wide     = cfg_wide_r;

    // Strobes pass two flops; the third stage gives edges
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cs_s_r <= 3'b111;
            rd_s_r <= 3'b111;
            wr_s_r <= 3'b111;
        end else begin
            cs_s_r <= {cs_s_r[1:0], pins.cs_n};
            rd_s_r <= {rd_s_r[1:0], pins.rd_n};
            wr_s_r <= {wr_s_r[1:0], pins.wr_n};
        end
    end
    assign cs_act  = !cs_s_r[1];
    assign rd_act  = !rd_s_r[1] && cs_act;
    assign wr_act  = !wr_s_r[1];
    assign rd_fall = rd_act && rd_s_r[2];
    // Write completes on strobe release or chip select release
    assign wr_rise = !wr_s_r[2] && (wr_s_r[1] || cs_s_r[1]) && !cs_s_r[2];
    // Address is stable by the strobe edge, read straight from the pins
    assign acc = !wide ? (pins.addr[0] ? PHBP_ACC_HIGH : PHBP_ACC_LOW)
                       : phbp_decode(pins.addr[0], pins.byte_high_enable_n);

    // Request from the sync front end crosses as a toggle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sreq_s_r <= 4'h0;
        end else begin
            sreq_s_r <= {sreq_s_r[2:0], sreq_tgl};
        end
    end

    // Posted write engine and read sequencing
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ast_r         <= PHBP_A_IDLE;
            wcnt_r        <= 6'h00;
            rcnt_r        <= 6'h00;
            wpend_r       <= 1'b0;
            rd_pend_r     <= 1'b0;
            last_waddr_r  <= 16'h0000;
            last_wbyte_r  <= 1'b0;
            last_wvalid_r <= 1'b0;
            rd_addr_r     <= 16'h0000;
            rd_bhe_r      <= 1'b1;
            mem_req       <= '0;
            mem_valid     <= 1'b0;
            sdone_tgl_r   <= 1'b0;
            held_rdata_r  <= 16'h0000;
            error_count   <= `PHBP_ERRCNT_RESET;
        end else begin
            mem_valid <= 1'b0;
            // Internal write keeps running after chip select drops
            if (wpend_r) begin
                if (wcnt_r == 6'h00) begin
                    wpend_r <= 1'b0;
                end else begin
                    wcnt_r <= wcnt_r - 6'h01;
                end
            end
            if (is_async && wr_rise) begin
                if (acc == PHBP_ACC_BAD) begin
                    error_count <= error_count + 8'h01;
                end else if (!wpend_r || wcnt_r == 6'h00) begin
                    // Posted: no busy unless an earlier write still runs
                    mem_req.write <= 1'b1;
                    mem_req.addr  <= pins.addr;
                    mem_req.lanes <= acc == PHBP_ACC_WORD ? 2'b11 :
                                     acc == PHBP_ACC_HIGH ? 2'b10 : 2'b01;
                    mem_req.wdata <= pins.data;
                    mem_valid     <= 1'b1;
                    wpend_r       <= 1'b1;
                    wcnt_r        <= acc == PHBP_ACC_WORD ? 6'(WR16_CYC) : 6'(WR8_CYC);
                    last_waddr_r  <= pins.addr;
                    last_wbyte_r  <= acc != PHBP_ACC_WORD;
                    last_wvalid_r <= 1'b1;
                end else begin
                    // Host broke the busy handshake of the earlier write
                    error_count <= error_count + 8'h01;
                end
            end
            case (ast_r)
                PHBP_A_IDLE: begin
                    if (is_async && rd_fall) begin
                        if (acc == PHBP_ACC_BAD) begin
                            error_count <= error_count + 8'h01;
                            ast_r       <= PHBP_A_HOLD;
                        end else begin
                            rd_addr_r <= pins.addr;
                            rd_bhe_r  <= pins.byte_high_enable_n;
                            rd_pend_r <= 1'b1;
                            rcnt_r    <= 6'((acc == PHBP_ACC_WORD ? RD16_CYC : RD8_CYC)
                                        + (last_wvalid_r && last_wbyte_r &&
                                           pins.addr == last_waddr_r ? COLL_CYC : 0)
                                        + (read_busy_delay ? RDDLY_CYC : 0));
                            ast_r     <= PHBP_A_READ;
                        end
                    end
                end
                PHBP_A_READ: begin
                    if (!rd_act) begin
                        // Aborted read: counted, nothing more done
                        error_count <= error_count + 8'h01;
                        rd_pend_r   <= 1'b0;
                        ast_r       <= PHBP_A_IDLE;
                    end else if (!wpend_r) begin
                        // Read starts only after the pending write ends
                        if (rcnt_r == 6'h00) begin
                            held_rdata_r <= mem_rdata;
                            rd_pend_r    <= 1'b0;
                            last_wvalid_r <= 1'b0;
                            ast_r        <= PHBP_A_HOLD;
                        end else begin
                            if (rd_pend_r) begin
                                mem_req.write <= 1'b0;
                                mem_req.addr  <= rd_addr_r;
                                mem_req.lanes <= {rd_addr_r[0] | wide & !rd_bhe_r, !rd_addr_r[0]};
                                mem_valid     <= 1'b1;
                                rd_pend_r     <= 1'b0;
                            end
                            rcnt_r <= rcnt_r - 6'h01;
                        end
                    end
                end
                PHBP_A_HOLD: begin
                    if (!rd_act) begin
                        ast_r <= PHBP_A_IDLE;
                    end
                end
                default: ast_r <= PHBP_A_IDLE;
            endcase
            // Sync variant requests, served one at a time
            if (is_sync && sreq_s_r[2] != sreq_s_r[1]) begin
                if (sreq.lanes == 2'b10 && !sreq.addr[0] ||
                    sreq.lanes == 2'b00) begin
                    error_count <= error_count + 8'h01;
                end else begin
                    mem_req   <= sreq;
                    mem_valid <= 1'b1;
                end
            end
            // Data taken once memory sees the address
            if (is_sync && sreq_s_r[3] != sreq_s_r[2]) begin
                held_rdata_r <= mem_rdata;
                sdone_tgl_r  <= !sdone_tgl_r;
            end
        end
    end

    // Pin outputs, busy driven only under chip select
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy_n   <= 1'b1;
            busy_oe  <= 1'b0;
            data_out <= 16'h0000;
            data_oe  <= 1'b0;
            irq_n    <= 1'b1;
            loaded   <= 1'b0;
        end else begin
            busy_oe  <= is_async && cs_act;
            busy_n   <= !(ast_r == PHBP_A_READ || rd_fall ||
                          (wr_act && wpend_r && wcnt_r != 6'h00));
            data_out <= held_rdata_r;
            data_oe  <= is_async && ast_r == PHBP_A_HOLD && rd_act;
            irq_n    <= !irq_in;
            loaded   <= config_loaded;
        end
    end

    phbp_sync_port u_sync (
        .host_clk                (host_clk),
        .host_rst                (host_rst),
        .enable                  (1'b1),
        .wide                    (wide),
        .cs_n                    (pins.cs_n),
        .transfer_start_strobe_n (transfer_start_strobe_n),
        .read_not_write_select   (read_not_write_select),
        .byte_high_enable_n      (pins.byte_high_enable_n),
        .addr                    (pins.addr),
        .wdata                   (pins.data),
        .req_tgl                 (sreq_tgl),
        .req                     (sreq),
        .done_tgl                (sdone_tgl_r),
        .rdata                   (held_rdata_r),
        .transfer_ack_n          (transfer_ack_n),
        .dout                    (sync_data_out),
        .dout_oe                 (sync_data_oe)
    );

endmodule : phbp_host_port

// ==== dv/phbp_monitor.sv ====
`timescale 1ns/10ps
// Port checker; async rules on ref_clk, ack rule on host_clk
module phbp_monitor (
    input wire logic                 ref_clk,
    input wire logic                 srst,
    input wire logic                 host_clk,
    input wire logic                 host_rst,
    input wire phbp_pkg::phbp_pins_t pins,
    input wire logic                 irq_in,
    input wire logic [15:0]          data_out,
    input wire logic                 data_oe,
    input wire logic                 busy_n,
    input wire logic                 busy_oe,
    input wire logic                 transfer_ack_n,
    input wire logic                 irq_n,
    input wire logic                 loaded,
    input wire logic [7:0]           error_count,
    input wire phbp_pkg::phbp_req_t  mem_req,
    input wire logic                 mem_valid
);
    import phbp_pkg::*;
    logic [7:0] busy_len_r;
    // Busy run length, saturating so a stuck busy still trips the bound
    always_ff @(posedge ref_clk) begin
        if (srst || busy_n) busy_len_r <= 8'h00;
        else if (busy_len_r != 8'hff) busy_len_r <= busy_len_r + 8'h01;
    end
    sequence s_cs_idle;
        pins.cs_n [*6];
    endsequence
    property p_busy_release;
        @(posedge ref_clk) disable iff (srst) s_cs_idle |-> !busy_oe;
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy driven unselected");
    property p_busy_sync;
        @(posedge ref_clk) disable iff (srst)
            $rose(busy_oe) |-> !$past(pins.cs_n) && !$past(pins.cs_n, 2);
    endproperty
    a_busy_sync: assert property (p_busy_sync) else $error("busy before select settled");
    property p_data_release;
        @(posedge ref_clk) disable iff (srst) pins.rd_n [*6] |-> !data_oe;
    endproperty
    a_data_release: assert property (p_data_release) else $error("data driven unread");
    property p_data_hold;
        @(posedge ref_clk) disable iff (srst) data_oe && $past(data_oe) |-> $stable(data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("read data moved");
    property p_lanes;
        @(posedge ref_clk) disable iff (srst) mem_valid |->
            (mem_req.lanes == 2'b01 && !mem_req.addr[0]) ||
            (mem_req.lanes == 2'b10 && mem_req.addr[0]) ||
            (mem_req.lanes == 2'b11 && !mem_req.addr[0]);
    endproperty
    a_lanes: assert property (p_lanes) else $error("bad lane decode reached memory");
    property p_err_step;
        @(posedge ref_clk) disable iff (srst)
            error_count != $past(error_count) |-> error_count == $past(error_count) + 8'h01;
    endproperty
    a_err_step: assert property (p_err_step) else $error("error count jumped");
    property p_busy_max;
        @(posedge ref_clk) disable iff (srst) busy_len_r <= 8'h64;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_irq_loaded;
        @(posedge ref_clk) disable iff (srst) $rose(loaded) |-> irq_n == !$past(irq_in);
    endproperty
    a_irq_loaded: assert property (p_irq_loaded) else $error("irq not valid at load");
    property p_ack_pulse;
        @(posedge host_clk) disable iff (host_rst) !transfer_ack_n |=> transfer_ack_n;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one clock");
endmodule : phbp_monitor
bind phbp_host_port phbp_monitor u_mon (.ref_clk, .srst, .host_clk, .host_rst, .pins,
    .irq_in, .data_out, .data_oe, .busy_n, .busy_oe, .transfer_ack_n, .irq_n, .loaded,
    .error_count, .mem_req, .mem_valid);

// ==== dv/phbp_mem_model.sv ====
`timescale 1ns/10ps
// Internal memory stand-in; read data follows the held request at once
module phbp_mem_model (
    input wire logic                ref_clk,
    input wire logic                srst,
    input wire phbp_pkg::phbp_req_t mem_req,
    input wire logic                mem_valid,
    output logic [15:0]             mem_rdata,
    output int                      wr_cnt
);
    import phbp_pkg::*;
    logic [7:0] mem_r [0:255];
    // Even byte on the low lane, odd byte on the high lane
    always_ff @(posedge ref_clk) begin
        if (mem_valid && mem_req.write && mem_req.lanes[0])
            mem_r[{mem_req.addr[7:1], 1'b0}] <= mem_req.wdata[7:0];
        if (mem_valid && mem_req.write && mem_req.lanes[1])
            mem_r[{mem_req.addr[7:1], 1'b1}] <= mem_req.wdata[15:8];
    end
    // Performed writes, to spot dropped accesses
    always_ff @(posedge ref_clk) begin
        if (srst) wr_cnt <= 0;
        else if (mem_valid && mem_req.write) wr_cnt <= wr_cnt + 1;
    end
    assign mem_rdata = {mem_r[{mem_req.addr[7:1], 1'b1}], mem_r[{mem_req.addr[7:1], 1'b0}]};
endmodule : phbp_mem_model

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`include "phbp_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
// Async and sync host traffic against the memory stand-in
module tb_top;
    import phbp_pkg::*;
    localparam int RD8 = `PHBP_CYC(`PHBP_T_READ8_NS);
    localparam int RD16 = `PHBP_CYC(`PHBP_T_READ16_NS);
    localparam int COLL = `PHBP_CYC(`PHBP_T_COLL_NS);
    localparam int DLY = `PHBP_CYC(`PHBP_T_RDDLY_NS);
    logic        ref_clk = 0, srst = 1, host_clk = 0, host_rst = 1;
    logic [7:0]  itype = 8'h08;
    logic        rbd = 0, cfg = 0, irq_in = 1, ts_n = 1, rnw = 0;
    phbp_pins_t  pins = '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0000, 16'h0000};
    logic [15:0] data_out, sync_data_out, mem_rdata;
    logic        data_oe, busy_n, busy_oe, ack_n, sync_data_oe, irq_n, loaded, mem_valid;
    logic [7:0]  error_count;
    phbp_req_t   mem_req;
    int          n_fail = 0, n_tests = 0, wr_cnt, la, lb, lw, l8;
    always #4 ref_clk = ~ref_clk;
    initial #3 forever #24 host_clk = ~host_clk;
    phbp_host_port dut (.ref_clk, .srst, .host_clk, .host_rst, .interface_type(itype),
        .read_busy_delay(rbd), .config_loaded(cfg), .irq_in, .pins,
        .transfer_start_strobe_n(ts_n), .read_not_write_select(rnw), .data_out, .data_oe,
        .busy_n, .busy_oe, .transfer_ack_n(ack_n), .sync_data_oe, .sync_data_out, .irq_n,
        .loaded, .error_count, .mem_req, .mem_valid, .mem_rdata);
    phbp_mem_model u_mem (.ref_clk, .srst, .mem_req, .mem_valid, .mem_rdata, .wr_cnt);
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // Strobe is held until busy clears, then the bus shows a changed pattern
    task automatic wr(input logic [15:0] a, input logic bh, input logic [15:0] d,
                      output logic saw);
        saw = 0;
        pins = '{1'b0, 1'b1, 1'b0, bh, a, d};
        for (int i = 0; i < 80 && (i < 5 || !busy_n); i++) begin
            cyc(1);
            if (busy_oe && !busy_n) saw = 1;
        end
        pins.wr_n = 1;
        cyc(3);
        pins = '{1'b1, 1'b1, 1'b1, 1'b1, ~a, ~d};
        cyc(1);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic bh, output int len,
                      output logic [15:0] q);
        pins = '{1'b0, 1'b0, 1'b1, bh, a, ~pins.data};
        len = 0;
        do begin
            cyc(1);
            len++;
        end while (len < 300 && (len < 4 || !busy_n || !data_oe));
        q = data_out;
        pins.rd_n = 1;
        cyc(1);
        pins.cs_n = 1;
        cyc(6);
        `CHK(busy_oe, 1'b0)
        `CHK(data_oe, 1'b0)
    endtask : rd
    task automatic sx(input logic r, input logic [15:0] a, input logic [15:0] d,
                      input logic late, output logic [15:0] q);
        int i;
        @(negedge host_clk);
        ts_n = 0;
        rnw = r;
        pins = '{late, 1'b1, 1'b1, 1'b0, a, d};
        @(negedge host_clk);
        ts_n = 1;
        pins.cs_n = 0;
        for (i = 0; i < 60 && ack_n !== 1'b0; i++) @(posedge host_clk) #1;
        q = sync_data_out;
        `CHK(sync_data_oe, r)
        @(posedge host_clk) #1;
        `CHK(i < 60, 1'b1)
        `CHK(ack_n, 1'b1)
        @(negedge host_clk);
        pins = '{1'b1, 1'b1, 1'b1, 1'b1, ~a, ~d};
    endtask : sx
    task automatic t_async;
        logic        s0, s1;
        logic [15:0] q;
        logic [7:0]  ec;
        int          wc;
        wr(16'h0010, 1'b0, 16'hbeef, s0);
        wr(16'h0012, 1'b0, 16'h1234, s1);
        `CHK(s0, 1'b0)
        `CHK(s1, 1'b1)
        cyc(60);
        rd(16'h0010, 1'b0, lw, q);
        `CHK(q, 16'hbeef)
        `CHK(lw >= RD16 && lw <= RD16 + 8, 1'b1)
        rd(16'h0012, 1'b1, l8, q);
        `CHK(q[7:0], 8'h34)
        `CHK(l8 >= RD8 && l8 <= RD8 + 8, 1'b1)
        rbd = 1;
        rd(16'h0012, 1'b1, la, q);
        `CHK(la, l8 + DLY)
        rbd = 0;
        wr(16'h0030, 1'b1, 16'h005a, s0);
        rd(16'h0030, 1'b1, la, q);
        `CHK(q[7:0], 8'h5a)
        wr(16'h0030, 1'b1, 16'h005a, s0);
        rd(16'h0012, 1'b1, lb, q);
        `CHK(la - lb, COLL)
        `CHK(lb > l8, 1'b1)
        wr(16'h0020, 1'b0, 16'h55aa, s0);
        rd(16'h0020, 1'b0, la, q);
        `CHK(q, 16'h55aa)
        `CHK(la > lw, 1'b1)
        ec = error_count;
        wc = wr_cnt;
        wr(16'h0041, 1'b1, 16'hffff, s0);
        cyc(40);
        `CHK(error_count, ec + 8'h01)
        `CHK(wr_cnt, wc)
    endtask : t_async
    task automatic t_sync;
        logic [15:0] q;
        itype = 8'h0b;
        sx(1'b0, 16'h0060, 16'h0077, 1'b0, q);
        itype = 8'h0a;
        sx(1'b0, 16'h0050, 16'hc3a5, 1'b0, q);
        sx(1'b1, 16'h0060, 16'h0000, 1'b1, q);
        `CHK(q[7:0], 8'h77)
        sx(1'b1, 16'h0050, 16'h0000, 1'b0, q);
        `CHK(q, 16'hc3a5)
    endtask : t_sync
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    // Reset, load indication and interrupt, then both port variants
    initial begin
        cyc(8);
        srst = 0;
        host_rst = 0;
        `CHK(busy_oe, 1'b0)
        `CHK(loaded, 1'b0)
        `CHK(error_count, 8'h00)
        cyc(3);
        cfg = 1;
        cyc(3);
        `CHK(loaded, 1'b1)
        `CHK(irq_n, 1'b0)
        irq_in = 0;
        cyc(3);
        `CHK(irq_n, 1'b1)
        t_async;
        t_sync;
        test_done;
    end
    // Hang guard, well past the run's length
    initial begin
        #100000;
        n_fail++;
        test_done;
    end
endmodule : tb_top
